// ---- rtl/pwm_cfg.svh ----
// Constants for the four-channel duty pulse generator.
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
`define PWM_CLK_HZ 100000000
`define PWM_DUTY_MAX 16'h03E8
`define PWM_FREQ_MAX_FINE 32'h0000FFFF
`define PWM_FREQ_MAX_COARSE 32'h00008020
`define PWM_FREQ_MIN 32'h00000001
`define PWM_FINE_SCALE 10
`define PWM_DUTY_SCALE 1000
`define PWM_BIT_CH_EVEN 4
`define PWM_BIT_CH_ODD 5
`define PWM_FLAG_BIT_EVEN 0
`define PWM_FLAG_BIT_ODD 8
`define PWM_MODE_ORG1 2'h1
`define PWM_MODE_ORG2 2'h2
`endif

// ---- rtl/pwm_pkg.sv ----
// Types shared by the pulse generator files.
package pwm_pkg;
  // Per-channel start command contents.
  typedef struct packed {
    logic fine;
    logic [15:0] freq;
    logic [15:0] duty;
  } pwm_cmd_s;
  typedef enum logic [0:0] {
    CH_IDLE = 1'b0,
    CH_RUN = 1'b1
  } ch_state_e;
endpackage : pwm_pkg

// ---- rtl/pwm_channel.sv ----
// One pulse channel: period and on-time counters.
`timescale 1ns/1ps
`include "pwm_cfg.svh"
module pwm_channel
  import pwm_pkg::*;
#(
  parameter int CNT_W = 32
)
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic clear_in,
  input wire logic start_in,
  input wire logic duty_in,
  input wire logic stop_in,
  input wire pwm_cmd_s cmd_in,
  output logic pulse_out,
  output logic busy_out
);
  initial
  begin
    if (CNT_W < 30)
    begin
      $error("pwm_channel: counter too narrow");
    end
  end

  ch_state_e state_r, state_nxt;
  logic [CNT_W-1:0] period_r, period_nxt, on_r, on_nxt, cnt_r, cnt_nxt;
  logic pulse_r, pulse_nxt;
  logic [63:0] per_calc, on_calc;
  logic [63:0] hz_x;

  // Clock cycles per period from the commanded frequency; fine steps are tenths of hertz.
  always_comb
  begin
    hz_x = cmd_in.fine ? 64'(cmd_in.freq) : 64'(cmd_in.freq) * 64'(`PWM_FINE_SCALE);
    if (hz_x == 64'h0)
    begin
      hz_x = 64'h1;
    end
    per_calc = (64'(`PWM_CLK_HZ) * 64'(`PWM_FINE_SCALE)) / hz_x;
    on_calc = (64'(period_r) * 64'(cmd_in.duty)) / 64'(`PWM_DUTY_SCALE);
  end

  // Next-state logic; a duty change recomputes on-time only, so the train keeps its phase.
  always_comb
  begin
    state_nxt = state_r;
    period_nxt = period_r;
    on_nxt = on_r;
    cnt_nxt = cnt_r;
    if (clear_in || stop_in)
    begin
      state_nxt = CH_IDLE; // see [R3] [R9]
      cnt_nxt = '0;
    end
    else if (start_in)
    begin
      state_nxt = CH_RUN; // see [R9] [R12]
      period_nxt = per_calc[CNT_W-1:0];
      on_nxt = CNT_W'((per_calc * 64'(cmd_in.duty)) / 64'(`PWM_DUTY_SCALE));
      cnt_nxt = '0;
    end
    else
    begin
      if (duty_in && state_r == CH_RUN)
      begin
        on_nxt = on_calc[CNT_W-1:0]; // see [R2]
      end
      if (state_r == CH_RUN)
      begin
        cnt_nxt = (cnt_r + CNT_W'(1) >= period_r) ? '0 : cnt_r + CNT_W'(1); // see [R12] [R13]
      end
    end
    pulse_nxt = (state_nxt == CH_RUN) && (cnt_nxt < on_nxt); // see [R1] [R13]
  end

  // State registers.
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      state_r <= CH_IDLE; // see [R8]
      period_r <= '0;
      on_r <= '0;
      cnt_r <= '0;
      pulse_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      period_r <= period_nxt;
      on_r <= on_nxt;
      cnt_r <= cnt_nxt;
      pulse_r <= pulse_nxt;
    end
  end

  assign pulse_out = pulse_r;
  assign busy_out = (state_r == CH_RUN);

  a_stop_low: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    stop_in && !start_in |=> !pulse_out && !busy_out) else $error("pin high after stop"); // see [R3]
  a_start_busy: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    start_in && !stop_in && !clear_in |=> busy_out) else $error("not busy after start"); // see [R9]
  a_duty_keeps: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    duty_in && busy_out && !stop_in && !clear_in && !start_in |=> busy_out && $stable(period_r))
    else $error("duty change disturbed run"); // see [R2]
  a_idle_low: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !busy_out |-> !pulse_out) else $error("pulse while idle"); // see [R1]
  a_cnt_wrap: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    busy_out && cnt_r + CNT_W'(1) >= period_r && !stop_in && !clear_in && !start_in
    |=> cnt_r == '0) else $error("period counter did not wrap"); // see [R13]
endmodule : pwm_channel

// ---- rtl/four_channel_duty_pwm.sv ----
// Top of the four-channel variable-duty pulse generator with terminal sharing.
`timescale 1ns/1ps
`include "pwm_cfg.svh"
// Summary of operation
// [R1] Each running channel outputs periodic pulses with on fraction equal to duty.
// [R2] A new duty on a running channel applies without restarting its train.
// [R3] Stop command halts the channel and leaves its pin low; the pin then takes the normal output or counter reset level.
// [R4] Channels 0,1 drive bits 4,5 of word one; channels 2,3 of word two.
// [R5] A terminal owned by pulse output blocks normal output and counter reset.
// [R6] Counter reset on a terminal exists only for origin search modes 1 or 2.
// [R7] Each channel has a read-only flag, bit 0 or 8, high while pulsing.
// [R8] Power-on reset clears all in-progress flags.
// [R9] Flags clear on controller run start or stop, update on channel start/stop.
// [R10] Duty spans 0.0 to 100.0 percent in tenths.
// [R11] Frequency 0.1 to 6553.5 Hz in tenths, or 1 to 32800 Hz.
// [R12] Channels run continuously until stopped, with no pulse count.
// [R13] Period and on-time are counted in system clocks, high then low.
module four_channel_duty_pwm
  import pwm_pkg::*;
#(
  parameter int CHANNELS = 4
)
(
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic run_change_in,
  input wire logic [3:0] start_in,
  input wire logic [3:0] duty_change_in,
  input wire logic [3:0] output_stop_command_in,
  input wire pwm_cmd_s [3:0] cmd_in,
  input wire logic [3:0] normal_out_in,
  input wire logic [3:0] counter_reset_in,
  input wire logic [3:0] [1:0] origin_mode_in,
  output logic pulse_pin_zero_out,
  output logic pulse_pin_one_out,
  output logic pulse_pin_two_out,
  output logic pulse_pin_three_out,
  output logic [15:0] out_word_lo_out,
  output logic [15:0] out_word_hi_out,
  output logic [15:0] status_lo_out,
  output logic [15:0] status_hi_out,
  output logic [3:0] cmd_error_out
);
  initial
  begin
    if (CHANNELS != 4)
    begin
      $error("four_channel_duty_pwm: exactly four channels supported");
    end
  end

  logic [3:0] pulse, busy, start_ok, err_nxt;
  logic [3:0] err_r;
  logic [3:0] pin_nxt, pin_r;

  // Commands outside the duty or frequency range are refused and flagged.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      start_ok[i] = (cmd_in[i].duty <= `PWM_DUTY_MAX) // see [R10]
        && (32'(cmd_in[i].freq) >= `PWM_FREQ_MIN)
        && (cmd_in[i].fine ? (32'(cmd_in[i].freq) <= `PWM_FREQ_MAX_FINE)
                           : (32'(cmd_in[i].freq) <= `PWM_FREQ_MAX_COARSE)); // see [R11]
      err_nxt[i] = (start_in[i] || duty_change_in[i]) && !start_ok[i];
    end
  end

  // Channel instances; run_change_in clears every flag at once.
  for (genvar g = 0; g < 4; g++)
  begin : g_ch
    pwm_channel #(.CNT_W(32)) u_ch (
      .sys_clk_in(sys_clk_in),
      .srst_in(srst_in),
      .clear_in(run_change_in), // see [R9]
      .start_in(start_in[g] && start_ok[g]),
      .duty_in(duty_change_in[g] && start_ok[g]),
      .stop_in(output_stop_command_in[g]),
      .cmd_in(cmd_in[g]),
      .pulse_out(pulse[g]),
      .busy_out(busy[g])
    );
  end

  // Terminal ownership: pulse output wins; else counter reset in origin modes; else normal.
  always_comb
  begin
    for (int i = 0; i < 4; i++)
    begin
      if (busy[i])
      begin
        pin_nxt[i] = pulse[i]; // see [R5]
      end
      else if ((origin_mode_in[i] == `PWM_MODE_ORG1) || (origin_mode_in[i] == `PWM_MODE_ORG2))
      begin
        pin_nxt[i] = counter_reset_in[i]; // see [R6]
      end
      else
      begin
        pin_nxt[i] = normal_out_in[i];
      end
    end
  end

  // Registered pins and error flags.
  always_ff @(posedge sys_clk_in)
  begin
    if (srst_in)
    begin
      pin_r <= 4'h0;
      err_r <= 4'h0;
    end
    else
    begin
      pin_r <= pin_nxt;
      err_r <= err_nxt;
    end
  end

  assign pulse_pin_zero_out = pin_r[0];
  assign pulse_pin_one_out = pin_r[1];
  assign pulse_pin_two_out = pin_r[2];
  assign pulse_pin_three_out = pin_r[3];
  assign cmd_error_out = err_r;

  // Output and status word images.
  always_comb
  begin
    out_word_lo_out = 16'h0000;
    out_word_hi_out = 16'h0000;
    status_lo_out = 16'h0000;
    status_hi_out = 16'h0000;
    out_word_lo_out[`PWM_BIT_CH_EVEN] = pin_r[0]; // see [R4]
    out_word_lo_out[`PWM_BIT_CH_ODD] = pin_r[1];
    out_word_hi_out[`PWM_BIT_CH_EVEN] = pin_r[2];
    out_word_hi_out[`PWM_BIT_CH_ODD] = pin_r[3];
    status_lo_out[`PWM_FLAG_BIT_EVEN] = busy[0]; // see [R7]
    status_lo_out[`PWM_FLAG_BIT_ODD] = busy[1];
    status_hi_out[`PWM_FLAG_BIT_EVEN] = busy[2];
    status_hi_out[`PWM_FLAG_BIT_ODD] = busy[3];
  end

  a_owner_pwm: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    busy[0] |=> pulse_pin_zero_out == $past(pulse[0])) else $error("terminal not owned"); // see [R5]
  a_run_clear: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    run_change_in |=> status_lo_out == 16'h0000 && status_hi_out == 16'h0000)
    else $error("flags not cleared"); // see [R9]
  a_bad_duty: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    start_in[0] && cmd_in[0].duty > `PWM_DUTY_MAX |=> cmd_error_out[0])
    else $error("bad duty accepted"); // see [R10]

  // The flags must read zero on the edge after any reset edge, since software polls them early.
  a_flags_reset: assert property (@(posedge sys_clk_in)
    srst_in |=> status_lo_out == 16'h0000 && status_hi_out == 16'h0000)
    else $error("flags not cleared by reset"); // see [R8]

  // Word images mirror the registered pins of channels 1 to 3 bit for bit.
  a_word_map: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    out_word_lo_out[`PWM_BIT_CH_ODD] == pulse_pin_one_out
    && out_word_hi_out[`PWM_BIT_CH_EVEN] == pulse_pin_two_out
    && out_word_hi_out[`PWM_BIT_CH_ODD] == pulse_pin_three_out)
    else $error("word image differs from pins"); // see [R4]

  // Status images mirror the running state of channels 1 to 3.
  a_status_map: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    status_lo_out[`PWM_FLAG_BIT_ODD] == busy[1]
    && status_hi_out[`PWM_FLAG_BIT_EVEN] == busy[2]
    && status_hi_out[`PWM_FLAG_BIT_ODD] == busy[3])
    else $error("status image differs from state"); // see [R7]

  // A refused start or duty change is taken as one step: the flag pulse follows.
  sequence s_refused_req(int ch);
    (start_in[ch] || duty_change_in[ch]) && !start_ok[ch];
  endsequence

  // Per-channel checks on terminal sourcing and refusal.
  // They stay next to the ownership logic so a change of priority is caught here first.
  for (genvar g = 0; g < 4; g++)
  begin : g_chk
    // An idle terminal in an origin-search mode follows the counter reset level.
    a_origin_src: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      !busy[g] && (origin_mode_in[g] == `PWM_MODE_ORG1 || origin_mode_in[g] == `PWM_MODE_ORG2)
      |=> pin_r[g] == $past(counter_reset_in[g])) else $error("origin source lost"); // see [R6]
    // An idle terminal outside those modes follows the normal output level.
    a_normal_src: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      !busy[g] && origin_mode_in[g] != `PWM_MODE_ORG1 && origin_mode_in[g] != `PWM_MODE_ORG2
      |=> pin_r[g] == $past(normal_out_in[g])) else $error("normal source lost"); // see [R5]
    // Every refused request raises the error flag on the next edge.
    a_refuse_flag: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      s_refused_req(g) |=> cmd_error_out[g]) else $error("refusal not flagged"); // see [R11]
    // A refused start must not wake an idle channel.
    a_refuse_idle: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      !busy[g] && start_in[g] && !start_ok[g] |=> !busy[g])
      else $error("refused start ran"); // see [R10]
  end
endmodule : four_channel_duty_pwm

// ---- testbench/pwm_load.sv ----
// Load model that times the high phase and the period of one pulse pin.
`timescale 1ns/1ps
module pwm_load
(
  input wire logic sys_clk_in,
  input wire logic pin_in,
  output int high_out,
  output int period_out
);
  int hi_c = 0;
  int per_c = 0;
  logic last = 1'b0;
  // A rising pin closes one cycle, so both counts are latched there.
  always @(posedge sys_clk_in)
  begin
    last <= pin_in;
    if (pin_in && !last)
    begin
      high_out <= hi_c;
      period_out <= per_c;
      hi_c <= 1;
      per_c <= 1;
    end
    else
    begin
      hi_c <= hi_c + (pin_in ? 1 : 0);
      per_c <= per_c + 1;
    end
  end
endmodule : pwm_load

// ---- testbench/test_four_channel_duty_pwm.sv ----
// Self-checking bench for the four-channel duty pulse generator.
`timescale 1ns/1ps
module test_four_channel_duty_pwm;
  import pwm_pkg::*;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic run_chg = 1'b0;
  logic [3:0] start = 4'h0;
  logic [3:0] duty_chg = 4'h0;
  logic [3:0] stop_cmd = 4'h0;
  pwm_cmd_s [3:0] cmd = '0;
  logic [3:0] normal = 4'h0;
  logic [3:0] cres = 4'h0;
  logic [3:0] [1:0] omode = '0;
  logic p0, p1, p2, p3;
  logic [15:0] wlo, whi, slo, shi;
  logic [3:0] err;
  int high, period;
  int err_count = 0;
  int checks_done = 0;
  four_channel_duty_pwm four_channel_duty_pwm_inst (.sys_clk_in(sys_clk_in),
    .srst_in(srst_in), .run_change_in(run_chg), .start_in(start),
    .duty_change_in(duty_chg), .output_stop_command_in(stop_cmd), .cmd_in(cmd),
    .normal_out_in(normal), .counter_reset_in(cres), .origin_mode_in(omode),
    .pulse_pin_zero_out(p0), .pulse_pin_one_out(p1), .pulse_pin_two_out(p2),
    .pulse_pin_three_out(p3), .out_word_lo_out(wlo), .out_word_hi_out(whi),
    .status_lo_out(slo), .status_hi_out(shi), .cmd_error_out(err));
  pwm_load pwm_load_inst (.sys_clk_in(sys_clk_in), .pin_in(p0), .high_out(high),
    .period_out(period));
  // Free-running 100 MHz clock.
  initial forever #5 sys_clk_in = ~sys_clk_in;
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // One-cycle command pulses; the return lands just after the taking edge.
  task automatic go(input logic [3:0] s, input logic [3:0] d, input logic [3:0] p,
    input logic r);
    @(posedge sys_clk_in);
    start <= s;
    duty_chg <= d;
    stop_cmd <= p;
    run_chg <= r;
    @(posedge sys_clk_in);
    start <= 4'h0;
    duty_chg <= 4'h0;
    stop_cmd <= 4'h0;
    run_chg <= 1'b0;
    #1;
  endtask : go
  task automatic conclude();
    $display("Counts: checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : conclude
  // 20 kHz gives 5000 clocks; 40.0 percent gives 2000 high, 25.0 percent 1250.
  task automatic t_run();
    cmd[0] <= '{fine: 1'b0, freq: 16'h4E20, duty: 16'h0190};
    go(4'h1, 4'h0, 4'h0, 1'b0);
    chk(slo, 16'h0001);
    tick(5100);
    chk(high, 2000);
    chk(period, 5000);
    chk(wlo, 16'h0010);
    cmd[0].duty <= 16'h00FA;
    go(4'h0, 4'h1, 4'h0, 1'b0);
    chk(slo, 16'h0001);
    tick(10100);
    chk(high, 1250);
    chk(period, 5000);
    go(4'h0, 4'h0, 4'h1, 1'b0);
    tick(1);
    chk(slo, 16'h0000);
    tick(6000);
    chk(p0, 1'b0);
    $display("test run done");
  endtask : t_run
  // A duty of 100.1 percent is refused and the channel stays idle.
  task automatic t_refuse();
    cmd[1] <= '{fine: 1'b1, freq: 16'h0064, duty: 16'h03E9};
    go(4'h2, 4'h0, 4'h0, 1'b0);
    chk(err, 4'h2);
    chk(slo, 16'h0000);
    go(4'h0, 4'h2, 4'h0, 1'b0);
    chk(err, 4'h2);
    cmd[1] <= '{fine: 1'b0, freq: 16'h8021, duty: 16'h01F4};
    go(4'h2, 4'h0, 4'h0, 1'b0);
    chk(err, 4'h2);
    chk(slo, 16'h0000);
    $display("test refuse done");
  endtask : t_refuse
  // Idle terminals show the normal level; a running channel owns its terminal.
  task automatic t_share();
    normal <= 4'h2;
    tick(3);
    chk(wlo, 16'h0020);
    normal <= 4'h0;
    cmd[1] <= '{fine: 1'b0, freq: 16'h4E20, duty: 16'h03E8};
    cmd[3] <= '{fine: 1'b0, freq: 16'h4E20, duty: 16'h03E8};
    go(4'hA, 4'h0, 4'h0, 1'b0);
    chk(slo, 16'h0100);
    chk(shi, 16'h0100);
    tick(3);
    chk(p1, 1'b1);
    chk(whi, 16'h0020);
    go(4'h0, 4'h0, 4'h0, 1'b1);
    tick(1);
    chk(slo | shi, 16'h0000);
    $display("test share done");
  endtask : t_share
  // Origin modes hand an idle terminal to the counter reset; pulse output still wins.
  task automatic t_origin();
    omode[2] <= 2'h1;
    cres <= 4'h4;
    tick(3);
    chk(p2, 1'b1);
    chk(whi, 16'h0010);
    omode[2] <= 2'h3;
    tick(3);
    chk(p2, 1'b0);
    normal <= 4'h4;
    tick(3);
    chk(p2, 1'b1);
    normal <= 4'h0;
    omode[2] <= 2'h2;
    cres <= 4'h0;
    cmd[2] <= '{fine: 1'b1, freq: 16'hFFFF, duty: 16'h03E8};
    go(4'h4, 4'h0, 4'h0, 1'b0);
    tick(3);
    chk(p2, 1'b1);
    chk(shi, 16'h0001);
    go(4'h0, 4'h0, 4'h4, 1'b0);
    tick(1);
    chk(p2, 1'b0);
    chk(shi, 16'h0000);
    omode[2] <= 2'h0;
    $display("test origin done");
  endtask : t_origin
  // Main sequence after a four-cycle reset.
  initial
  begin
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    tick(1);
    chk(slo | shi, 16'h0000);
    t_run();
    t_refuse();
    t_share();
    t_origin();
    conclude();
  end
  // The tests need about 21250 cycles; this cuts a hang short.
  initial
  begin
    #500us;
    err_count++;
    conclude();
  end
endmodule : test_four_channel_duty_pwm
